// file: design/bstap_regs.svh
// Constants of the boundary-scan test port: codes, widths, layouts.
// Assumes inclusion by bare name from the package and design modules.
// Function
// - Preload-sample (100) in Capture-DR copies all input and I/O pin levels.
// - Scan cells without a pin load their fixed default on every capture.
// - Preload-sample in Shift-DR puts the scan chain between data in and out.
// - Instruction code 000 runs external test.
// - External test never blocks or overrides the memory's functional inputs.
// - External test drives the scan chain onto outputs at Update-IR falling edge.
// - External test capture loads pins and defaults; I/O pin levels feed their cells.
// - Code 001 loads identity ROM at Capture-DR and shifts it in Shift-DR.
// - Identity instruction becomes current at power-up and in Test-Logic-Reset.
// - Code 010 forces memory outputs to high impedance, scan chain in Shift-DR.
// - Code 111 selects the single-bit bypass path.
// - Codes are three bits, most significant bit leftmost.
// - Instruction register is three bits; Capture-IR loads low bits with 01.
// - No test reset pin; five high mode-select edges reach Test-Logic-Reset.
// - Registers capture on rising test-clock edge, output on following falling.
// - Identity register is 32 bits, bit 0 shifted out first.
`ifndef BSTAP_REGS_SVH
`define BSTAP_REGS_SVH

`define IR_W 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPZ 3'h2
`define IR_PRELOAD 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_LOW 2'h1
`define ID_W 32
`define ID_CODE_DEFAULT 32'h0000_0A51 // Arbitrary value
`define N_IN 8
`define N_IO 8
`define N_FIX 2
`define BSR_W 18
`define BSR_IO_LSB 8
`define BSR_FIX_LSB 16
`define FIX_DEFAULT 2'h3
`define TLR_TMS_COUNT 5

`endif

// file: design/bstap_pkg.sv
// Types of the boundary-scan test port: controller states and state structs.
// Assumes the constants header sits beside it.
`include "bstap_regs.svh"

package bstap_pkg;

    typedef enum logic [3:0] {
        ST_TLR, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bstap_state_t;

    // Rising-edge state of the test-clock side
    typedef struct packed {
        logic [`IR_W-1:0] ir_sh;
        logic [`BSR_W-1:0] bsr;
        logic [`ID_W-1:0] idr;
        logic byp;
    } bstap_pos_t;

    // Falling-edge state of the test-clock side
    typedef struct packed {
        logic [`IR_W-1:0] instr;
        logic [`BSR_W-1:0] upd;
        logic upd_tgl;
        logic tdo;
        logic tdo_oe;
    } bstap_neg_t;

    // Memory-clock side of the output drivers
    typedef struct packed {
        logic [`N_IO-1:0] pad_q;
        logic pad_oe;
        logic [`BSR_W-1:0] upd_copy;
        logic tgl_seen;
    } bstap_ref_t;

endpackage

// file: design/bstap_sync.sv
// Two-flop synchroniser for a bundle of levels.
// Assumes bits of the bundle are independent levels or a gray/toggle code.
module bstap_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bstap_sync_t;

    bstap_sync_t r;
    bstap_sync_t next_r;

    // First stage feeds only the second
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;

endmodule

// file: design/bstap_fsm.sv
// Test access port controller state machine, clocked by the test clock.
// Assumes mode select is already in the test-clock domain.
module bstap_fsm (
    input wire logic tck,
    input wire logic rst_n,
    input wire logic tms,
    output bstap_pkg::bstap_state_t state
);

    bstap_pkg::bstap_state_t next_state;

    always_comb begin
        case (state)
            bstap_pkg::ST_TLR: next_state = tms ? bstap_pkg::ST_TLR : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_IDLE: next_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_DR: next_state = tms ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
            bstap_pkg::ST_CAP_DR: next_state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_SHIFT_DR: next_state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_EXIT1_DR: next_state = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_PAUSE_DR: next_state = tms ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_EXIT2_DR: next_state = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_UPD_DR: next_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_IR: next_state = tms ? bstap_pkg::ST_TLR : bstap_pkg::ST_CAP_IR;
            bstap_pkg::ST_CAP_IR: next_state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_SHIFT_IR: next_state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_EXIT1_IR: next_state = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_PAUSE_IR: next_state = tms ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_EXIT2_IR: next_state = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_UPD_IR: next_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
            default: next_state = bstap_pkg::ST_TLR;
        endcase
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            state <= bstap_pkg::ST_TLR;
        end else begin
            state <= next_state;
        end
    end

endmodule

// file: design/bstap_top.sv
// Boundary-scan test port: instruction decode, scan, identity and bypass paths.
// Assumes tck is free of ref_clk; memory pins are asynchronous to tck.
`include "bstap_regs.svh"

module bstap_top #(
    parameter logic [31:0] ID_CODE = `ID_CODE_DEFAULT // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`N_IN-1:0] pin_in,
    input wire logic [`N_IO-1:0] io_in,
    input wire logic [`N_IO-1:0] core_q,
    input wire logic core_oe,
    output logic [`N_IO-1:0] pad_q,
    output logic pad_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Resets and pin synchronisers

    logic tck_rst_n;
    logic [`N_IN-1:0] pin_s;
    logic [`N_IO-1:0] io_s;
    bstap_pkg::bstap_state_t state;

    // Power-up reset released on the test clock
    bstap_sync #(.W(1)) u_rst_sync (
        .clk(tck),
        .rst_n(nrst),
        .d(1'b1),
        .q(tck_rst_n)
    );

    // pin levels resynchronised; stable pins give repeatable capture
    bstap_sync #(.W(`N_IN + `N_IO)) u_pin_sync (
        .clk(tck),
        .rst_n(tck_rst_n),
        .d({io_in, pin_in}),
        .q({io_s, pin_s})
    );

    bstap_fsm u_fsm (
        .tck(tck),
        .rst_n(tck_rst_n),
        .tms(tms),
        .state(state)
    );

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode

    bstap_pkg::bstap_pos_t p;
    bstap_pkg::bstap_pos_t next_p;
    bstap_pkg::bstap_neg_t n;
    bstap_pkg::bstap_neg_t next_n;
    logic sel_bsr;
    logic sel_id;
    logic dr_out;

    function automatic logic [1:0] bstap_decode(input logic [`IR_W-1:0] code);
        case (code)
            `IR_EXTEST, `IR_SAMPZ, `IR_PRELOAD: bstap_decode = 2'h1;
            `IR_IDCODE: bstap_decode = 2'h2;
            default: bstap_decode = 2'h0;
        endcase
    endfunction

    assign {sel_id, sel_bsr} = bstap_decode(n.instr);

    // Output bit of the selected data register
    always_comb begin
        if (sel_bsr) begin
            dr_out = p.bsr[0];
        end else if (sel_id) begin
            dr_out = p.idr[0];
        end else begin
            dr_out = p.byp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rising-edge registers

    // capture and shift on the rising edge
    always_comb begin
        next_p = p;
        case (state)
            bstap_pkg::ST_CAP_IR: begin
                next_p.ir_sh = {1'b0, `IR_CAPTURE_LOW};
            end
            bstap_pkg::ST_SHIFT_IR: begin
                next_p.ir_sh = {tdi, p.ir_sh[`IR_W-1:1]};
            end
            bstap_pkg::ST_CAP_DR: begin
                // pins and I/O ring into the chain
                if (sel_bsr) begin
                    next_p.bsr = {`FIX_DEFAULT, io_s, pin_s};
                end
                if (sel_id) begin
                    next_p.idr = ID_CODE;
                end
                next_p.byp = 1'b0;
            end
            bstap_pkg::ST_SHIFT_DR: begin
                // chain shifts between data in and out
                if (sel_bsr) begin
                    next_p.bsr = {tdi, p.bsr[`BSR_W-1:1]};
                end
                if (sel_id) begin
                    next_p.idr = {tdi, p.idr[`ID_W-1:1]};
                end
                next_p.byp = tdi;
            end
            default: begin
                next_p = p;
            end
        endcase
    end

    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            p <= '0;
        end else begin
            p <= next_p;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Falling-edge registers

    // Instruction update, scan update and serial output
    always_comb begin
        next_n = n;
        next_n.tdo = 1'b0;
        next_n.tdo_oe = 1'b0;
        case (state)
            bstap_pkg::ST_TLR: begin
                next_n.instr = `IR_IDCODE;
            end
            bstap_pkg::ST_UPD_IR: begin
                next_n.instr = p.ir_sh;
                // all-zero code drives chain to outputs
                if (p.ir_sh == `IR_EXTEST) begin
                    next_n.upd = p.bsr;
                    next_n.upd_tgl = ~n.upd_tgl;
                end
            end
            bstap_pkg::ST_UPD_DR: begin
                if (n.instr == `IR_EXTEST || n.instr == `IR_PRELOAD) begin
                    next_n.upd = p.bsr;
                    next_n.upd_tgl = ~n.upd_tgl;
                end
            end
            bstap_pkg::ST_SHIFT_IR: begin
                next_n.tdo = p.ir_sh[0];
                next_n.tdo_oe = 1'b1;
            end
            bstap_pkg::ST_SHIFT_DR: begin
                next_n.tdo = dr_out;
                next_n.tdo_oe = 1'b1;
            end
            default: begin
                next_n.instr = n.instr;
            end
        endcase
    end

    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            n <= '{instr: `IR_IDCODE, upd: '0, upd_tgl: 1'b0, tdo: 1'b0, tdo_oe: 1'b0};
        end else begin
            n <= next_n;
        end
    end

    assign tdo = n.tdo;
    assign tdo_oe = n.tdo_oe;

    ////////////////////////////////////////////////////////////////////////
    // Memory-clock side of the output drivers

    logic mode_ext;
    logic mode_hiz;
    logic tgl_s;
    logic ext_s;
    logic hiz_s;
    bstap_pkg::bstap_ref_t r;
    bstap_pkg::bstap_ref_t next_r;

    // only real output codes steer the drivers
    assign mode_ext = (n.instr == `IR_EXTEST);
    assign mode_hiz = (n.instr == `IR_SAMPZ);

    // Modes and update toggle cross to the memory clock
    bstap_sync #(.W(3)) u_mode_sync (
        .clk(ref_clk),
        .rst_n(nrst),
        .d({n.upd_tgl, mode_hiz, mode_ext}),
        .q({tgl_s, hiz_s, ext_s})
    );

    // functional pins are only observed; high-impedance and external test modes override the core's drivers, else core keeps control
    always_comb begin
        next_r = r;
        next_r.tgl_seen = tgl_s;
        if (tgl_s != r.tgl_seen) begin
            next_r.upd_copy = n.upd;
        end
        if (hiz_s) begin
            next_r.pad_oe = 1'b0;
            next_r.pad_q = core_q;
        end else if (ext_s) begin
            next_r.pad_oe = 1'b1;
            next_r.pad_q = r.upd_copy[`BSR_FIX_LSB-1:`BSR_IO_LSB];
        end else begin
            next_r.pad_oe = core_oe;
            next_r.pad_q = core_q;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pad_q = r.pad_q;
    assign pad_oe = r.pad_oe;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers

    a_ir_capture_pattern: assert property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_CAP_IR |=> p.ir_sh == {1'b0, `IR_CAPTURE_LOW})
        else $error("capture-ir pattern wrong");

    a_idcode_on_reset: assert property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_TLR |=> n.instr == `IR_IDCODE)
        else $error("identity not current after reset state");

    a_identity_rom_load: assert property (@(posedge tck) disable iff (!tck_rst_n)
        (state == bstap_pkg::ST_CAP_DR && n.instr == `IR_IDCODE) |=> p.idr == ID_CODE)
        else $error("identity rom not captured");

    a_bsr_ring_capture: assert property (@(posedge tck) disable iff (!tck_rst_n)
        (state == bstap_pkg::ST_CAP_DR && (n.instr == `IR_PRELOAD || n.instr == `IR_EXTEST))
        |=> p.bsr == {`FIX_DEFAULT, $past(io_s), $past(pin_s)})
        else $error("scan chain capture wrong");

    a_bypass_one_bit: assert property (@(posedge tck) disable iff (!tck_rst_n)
        (state == bstap_pkg::ST_SHIFT_DR && !sel_bsr && !sel_id && tdi) ##1 state == bstap_pkg::ST_SHIFT_DR
        |-> tdo && tdo_oe)
        else $error("bypass path not one bit");

    a_ir_shift_out: assert property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_SHIFT_IR |-> tdo == p.ir_sh[0] && tdo_oe)
        else $error("instruction bit not on tdo");

    a_tlr_five_high: assert property (@(posedge tck) disable iff (!tck_rst_n)
        tms [*5] |=> state == bstap_pkg::ST_TLR)
        else $error("five high tms did not reset");

    a_id_lsb_first: assert property (@(posedge tck) disable iff (!tck_rst_n)
        (state == bstap_pkg::ST_CAP_DR && n.instr == `IR_IDCODE) ##1 state == bstap_pkg::ST_SHIFT_DR
        |-> tdo == ID_CODE[0])
        else $error("identity bit 0 not first");

    a_extest_update: assert property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_UPD_IR ##1 n.instr == `IR_EXTEST |-> n.upd == p.bsr)
        else $error("update word not loaded in update-ir");

    a_hiz_outputs: assert property (@(posedge ref_clk) disable iff (!nrst)
        hiz_s |=> !pad_oe)
        else $error("outputs not high impedance");

    a_extest_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ext_s && !hiz_s) |=> pad_oe && pad_q == $past(r.upd_copy[`BSR_FIX_LSB-1:`BSR_IO_LSB]))
        else $error("external test not driving outputs");

    c_idcode_shift: cover property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_SHIFT_DR && n.instr == `IR_IDCODE);
    c_preload_capture: cover property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_CAP_DR && n.instr == `IR_PRELOAD);
    c_extest_load: cover property (@(posedge tck) disable iff (!tck_rst_n)
        state == bstap_pkg::ST_UPD_IR && p.ir_sh == `IR_EXTEST);
    c_hiz_active: cover property (@(posedge ref_clk) disable iff (!nrst) hiz_s);

endmodule

// file: verification/bstap_ctrl_model.sv
// Model of the external test controller driving the serial test port.
// Assumes the device answers on tdo from the falling test-clock edge.
module bstap_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    output logic [31:0] rx_data,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock parked low, data line at its pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        rx_data = 32'h0000_0000;
        rx_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // One 32 ns test-clock period; tdo taken just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        o = tdo;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask

    task automatic go_tlr();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    // Walk from idle through capture, shift and update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] d);
        logic o;
        logic [31:0] got;
        got = 32'h0000_0000;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], o);
            got[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        rx_data = got;
        rx_valid = 1'b1;
        #1;
        rx_valid = 1'b0;
    endtask
endmodule

// file: verification/bstap_top_tb.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model owns tck, tms and tdi.
`include "bstap_regs.svh"

module bstap_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] ID_VAL = 32'h5C3A_96E1; // Arbitrary identity value
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } bstap_note_t;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [7:0] pin_in = 8'h00;
    logic [7:0] io_in = 8'h00;
    logic [7:0] core_q = 8'h00;
    logic core_oe = 1'b0;
    logic [7:0] pad_q;
    logic pad_oe;
    logic [31:0] rx_data;
    logic rx_valid;
    logic o_unused;
    logic [31:0] seed = 32'h0000_005B;
    logic [17:0] chain = 18'h0_0000;
    logic [17:0] upd = 18'h0_0000;
    logic [2:0] codes [8] = '{`IR_PRELOAD, `IR_EXTEST, `IR_SAMPZ, `IR_IDCODE, `IR_BYPASS, 3'h3, 3'h5, 3'h6};
    bstap_note_t notes[$];
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    bstap_top #(.ID_CODE(ID_VAL)) u_bstap_top (
        .ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_in(pin_in), .io_in(io_in), .core_q(core_q), .core_oe(core_oe), .pad_q(pad_q), .pad_oe(pad_oe)
    );

    bstap_ctrl_model u_bstap_ctrl_model (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .rx_data(rx_data), .rx_valid(rx_valid)
    );

    ////////////////////////////////////////////////////////////////
    // Memory clock and hang guard
    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Oldest note against each word shifted out
    always @(posedge rx_valid) begin
        bstap_note_t n;
        n = notes.pop_front();
        check("tdo_word", rx_data & n.mask, n.exp & n.mask);
    end

    task automatic stir();
        logic [31:0] r;
        r = rnd();
        @(negedge ref_clk);
        pin_in = r[7:0];
        io_in = r[15:8];
        core_q = r[23:16];
        core_oe = r[24];
    endtask

    // Output drivers once the crossing has settled
    task automatic pads(input logic [2:0] c);
        repeat (6) @(negedge ref_clk);
        check("tdo_oe_idle", 32'(tdo_oe), 32'h0000_0000);
        if (c == `IR_EXTEST) begin
            check("pad_extest", 32'({pad_oe, pad_q}), 32'({1'b1, upd[15:8]}));
        end else if (c == `IR_SAMPZ) begin
            check("pad_oe_hiz", 32'(pad_oe), 32'h0000_0000);
        end else begin
            check("pad_func", 32'({pad_oe, pad_q}), 32'({core_oe, core_q}));
        end
    endtask

    task automatic run_code(input logic [2:0] c);
        logic [31:0] d;
        stir();
        notes.push_back('{32'h0000_0001, 32'h0000_0003});
        u_bstap_ctrl_model.scan(1'b1, 3, {29'h0, c});
        if (c == `IR_EXTEST) upd = chain;
        pads(c);
        d = rnd();
        if (c == `IR_IDCODE) begin
            notes.push_back('{ID_VAL, 32'hFFFF_FFFF});
            u_bstap_ctrl_model.scan(1'b0, 32, d);
        end else if (c inside {`IR_EXTEST, `IR_SAMPZ, `IR_PRELOAD}) begin
            notes.push_back('{{14'h0, 2'h3, io_in, pin_in}, 32'h0003_FFFF});
            u_bstap_ctrl_model.scan(1'b0, 18, d);
            chain = d[17:0];
            if (c != `IR_SAMPZ) upd = chain;
        end else begin
            notes.push_back('{{24'h0, d[6:0], 1'b0}, 32'h0000_00FF});
            u_bstap_ctrl_model.scan(1'b0, 8, d);
        end
        pads(c);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fork
            u_bstap_ctrl_model.go_tlr();
            begin
                repeat (3) @(negedge ref_clk);
                nrst = 1'b1;
            end
        join
        u_bstap_ctrl_model.go_tlr();
        notes.push_back('{ID_VAL, 32'hFFFF_FFFF});
        u_bstap_ctrl_model.scan(1'b0, 32, rnd());
        foreach (codes[i]) run_code(codes[i]);
        u_bstap_ctrl_model.step(1'b1, 1'b1, o_unused);
        u_bstap_ctrl_model.step(1'b0, 1'b1, o_unused);
        u_bstap_ctrl_model.step(1'b0, 1'b1, o_unused);
        u_bstap_ctrl_model.go_tlr();
        notes.push_back('{ID_VAL, 32'hFFFF_FFFF});
        u_bstap_ctrl_model.scan(1'b0, 32, rnd());
        pads(`IR_IDCODE);
        summarize();
    end
endmodule
